// file: core/pidc_top.sv
// pidc_top: sampled pid loop calculator with an axi4-lite register slave.
// assumes pv samples arrive as one-cycle strobes, spaced wider than a loop calculation.
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module pidc_top import pidc_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [ADDR_W-1:0] I_AWADDR,
  input wire logic [2:0] I_AWPROT,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  input wire logic [2:0] I_ARPROT,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  input wire logic I_PV_VALID,
  input wire logic [11:0] I_PV,
  output logic O_CV_VALID,
  output logic [11:0] O_CV,
  output logic signed [12:0] O_CV_DELTA
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    pidc_ctrl_s ctrl;
    logic [11:0] sp;
    logic [31:0] gain;
    logic [15:0] ti;
    logic [15:0] td;
    logic [15:0] ts;
    logic [16:0] init;
    logic [11:0] lim_min;
    logic [11:0] lim_max;
    logic [11:0] manual;
    pidc_state_e st;
    logic [11:0] pv;
    logic [11:0] pv_last;
    logic [11:0] pv_prev;
    logic [11:0] sp_prev;
    logic [16:0] mx;
    logic [31:0] ki;
    logic [31:0] kr;
    logic first;
    logic auto_prev;
    logic at_limit;
    logic frozen;
    logic div_start;
    pidc_div_req_s div_req;
    logic cv_valid;
    logic [11:0] cv;
    logic signed [12:0] delta;
  } pidc_top_s;

  pidc_top_s s_r, s_nxt;
  logic div_done;
  logic [47:0] div_quo;
  logic aw_rdy, w_rdy, ar_rdy;
  logic [47:0] mul_num;
  logic signed [63:0] e, dpv, ie, pe, de, mxc, m, mcl, mxn;
  logic [11:0] cv_code;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic signed [63:0] mulq(input logic signed [63:0] a, input logic signed [63:0] b);
    logic signed [63:0] p;
    p = a * b;
    return p >>> PIDC_FRAC;
  endfunction : mulq

  function automatic logic signed [63:0] clamp01(input logic signed [63:0] v);
    logic signed [63:0] r;
    r = v;
    if (v < 64'sd0) begin
      r = 64'sd0;
    end else if (v > 64'(PIDC_ONE)) begin
      r = 64'(PIDC_ONE);
    end
    return r;
  endfunction : clamp01

  function automatic logic [31:0] sat31(input logic [47:0] q);
    return (q[47:31] != '0) ? 32'h7fff_ffff : q[31:0];
  endfunction : sat31

  function automatic logic signed [63:0] toq(input logic [11:0] c);
    return 64'({c, 4'h0});
  endfunction : toq

  assign aw_rdy = !s_r.aw_got && !s_r.bvalid;
  assign w_rdy = !s_r.w_got && !s_r.bvalid;
  assign ar_rdy = !s_r.rvalid;

  // ****************************************************************
  // loop arithmetic of the current sample
  // ****************************************************************
  always_comb begin
    mxn = 64'sd0;
    e = toq(s_r.sp) - toq(s_r.pv);
    dpv = toq(s_r.pv) - toq(s_r.pv_prev);
    ie = mulq(64'(s_r.ki), e);
    pe = mulq(64'((s_r.gain == '0) ? 32'h0 : s_r.gain), e);
    de = mulq(64'(s_r.kr), dpv);
    if (s_r.ctrl.reverse) begin
      mxc = 64'(s_r.mx) - ie;
      m = mxc - pe + de;
    end else begin
      mxc = 64'(s_r.mx) + ie;
      m = mxc + pe - de;
    end
    mcl = clamp01(m);
    if (m != mcl) begin
      if (s_r.ctrl.freeze) begin
        mxn = 64'(s_r.mx);
      end else begin
        mxn = mxc - (m - mcl);
      end
    end else begin
      mxn = mxc;
    end
    mxn = clamp01(mxn);
    cv_code = (mcl >= 64'(PIDC_ONE)) ? PIDC_CODE_MAX : 12'(mcl >>> PIDC_CONV_SHIFT);
    if (cv_code < s_r.lim_min) begin
      cv_code = s_r.lim_min;
    end else if (cv_code > s_r.lim_max) begin
      cv_code = s_r.lim_max;
    end
  end

  // ****************************************************************
  // register bus and sequencing
  // ****************************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.div_start = 1'b0;
    s_nxt.cv_valid = 1'b0;
    mul_num = '0;
    if (I_AWVALID && aw_rdy) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = 8'(I_AWADDR);
    end
    if (I_WVALID && w_rdy) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = I_WDATA;
      s_nxt.wstrb = I_WSTRB;
    end
    if (s_r.aw_got && s_r.w_got) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = PIDC_RESP_OKAY;
      unique case (s_r.awaddr)
        PIDC_OFF_CTRL: begin
          s_nxt.ctrl = pidc_ctrl_s'(5'(merge(32'(s_r.ctrl), s_r.wdata, s_r.wstrb)));
          if (s_r.wstrb[0] && s_r.wdata[PIDC_CTRL_LOAD_INIT]) begin
            s_nxt.mx = s_r.init;
          end
        end
        PIDC_OFF_SETPOINT: s_nxt.sp = 12'(merge(32'(s_r.sp), s_r.wdata, s_r.wstrb));
        PIDC_OFF_GAIN: s_nxt.gain = merge(s_r.gain, s_r.wdata, s_r.wstrb);
        PIDC_OFF_INTEG_TIME: s_nxt.ti = 16'(merge(32'(s_r.ti), s_r.wdata, s_r.wstrb));
        PIDC_OFF_DERIV_TIME: s_nxt.td = 16'(merge(32'(s_r.td), s_r.wdata, s_r.wstrb));
        PIDC_OFF_SAMPLE_PERIOD: s_nxt.ts = 16'(merge(32'(s_r.ts), s_r.wdata, s_r.wstrb));
        PIDC_OFF_INIT_OUT: s_nxt.init = 17'(merge(32'(s_r.init), s_r.wdata, s_r.wstrb));
        PIDC_OFF_OUT_LIMITS: begin
          s_nxt.lim_min = 12'(merge(32'(s_r.lim_min), s_r.wdata, s_r.wstrb));
          s_nxt.lim_max = 12'(merge(32'(s_r.lim_max), s_r.wdata >> PIDC_LIM_MAX_LSB, s_r.wstrb >> 2));
        end
        PIDC_OFF_MANUAL_OUT: s_nxt.manual = 12'(merge(32'(s_r.manual), s_r.wdata, s_r.wstrb));
        PIDC_OFF_STATUS, PIDC_OFF_BIAS, PIDC_OFF_INTEG_COEF, PIDC_OFF_DERIV_COEF: begin
        end
        default: s_nxt.bresp = PIDC_RESP_SLVERR;
      endcase
    end
    if (s_r.bvalid && I_BREADY) begin
      s_nxt.bvalid = 1'b0;
    end
    if (I_ARVALID && ar_rdy) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = PIDC_RESP_OKAY;
      unique case (8'(I_ARADDR))
        PIDC_OFF_CTRL: s_nxt.rdata = 32'(s_r.ctrl);
        PIDC_OFF_SETPOINT: s_nxt.rdata = 32'(s_r.sp);
        PIDC_OFF_GAIN: s_nxt.rdata = s_r.gain;
        PIDC_OFF_INTEG_TIME: s_nxt.rdata = 32'(s_r.ti);
        PIDC_OFF_DERIV_TIME: s_nxt.rdata = 32'(s_r.td);
        PIDC_OFF_SAMPLE_PERIOD: s_nxt.rdata = 32'(s_r.ts);
        PIDC_OFF_INIT_OUT: s_nxt.rdata = 32'(s_r.init);
        PIDC_OFF_OUT_LIMITS: s_nxt.rdata = (32'(s_r.lim_max) << PIDC_LIM_MAX_LSB) | 32'(s_r.lim_min);
        PIDC_OFF_MANUAL_OUT: s_nxt.rdata = 32'(s_r.manual);
        PIDC_OFF_STATUS: begin
          s_nxt.rdata = 32'(s_r.cv);
          s_nxt.rdata[PIDC_STAT_BUSY] = (s_r.st != PIDC_ST_IDLE);
          s_nxt.rdata[PIDC_STAT_LIMIT] = s_r.at_limit;
          s_nxt.rdata[PIDC_STAT_FROZEN] = s_r.frozen;
        end
        PIDC_OFF_BIAS: s_nxt.rdata = 32'(s_r.mx);
        PIDC_OFF_INTEG_COEF: s_nxt.rdata = s_r.ki;
        PIDC_OFF_DERIV_COEF: s_nxt.rdata = s_r.kr;
        default: begin
          s_nxt.rdata = 32'h0;
          s_nxt.rresp = PIDC_RESP_SLVERR;
        end
      endcase
    end
    if (s_r.rvalid && I_RREADY) begin
      s_nxt.rvalid = 1'b0;
    end

    // loop sequencing; samples arriving mid-calculation are only recorded
    if (I_PV_VALID) begin
      s_nxt.pv_last = I_PV;
    end
    unique case (s_r.st)
      PIDC_ST_IDLE: begin
        if (I_PV_VALID) begin
          s_nxt.pv = I_PV;
          if (s_r.ctrl.auto_mode) begin
            s_nxt.st = PIDC_ST_KI;
          end else begin
            // manual: operator value goes out, history tracks the process
            s_nxt.cv = s_r.manual;
            s_nxt.delta = 13'($signed({1'b0, s_r.manual}) - $signed({1'b0, s_r.cv}));
            s_nxt.cv_valid = 1'b1;
            s_nxt.pv_prev = I_PV;
            s_nxt.sp_prev = s_r.sp;
          end
        end
      end
      PIDC_ST_KI: begin
        mul_num = 48'((s_r.gain == '0) ? PIDC_RST_GAIN : s_r.gain) * 48'(s_r.ts);
        s_nxt.div_req = '{num: mul_num, den: s_r.ti};
        if (s_r.ti == PIDC_TI_OFF_LO || s_r.ti == PIDC_TI_OFF_HI) begin
          s_nxt.ki = 32'h0;
          s_nxt.st = PIDC_ST_KR;
        end else begin
          s_nxt.div_start = 1'b1;
          s_nxt.st = PIDC_ST_KI_W;
        end
      end
      PIDC_ST_KI_W: begin
        if (div_done) begin
          s_nxt.ki = sat31(div_quo);
          s_nxt.st = PIDC_ST_KR;
        end
      end
      PIDC_ST_KR: begin
        mul_num = 48'((s_r.gain == '0) ? PIDC_RST_GAIN : s_r.gain) * 48'(s_r.td);
        s_nxt.div_req = '{num: mul_num, den: s_r.ts};
        if (s_r.td == '0 || s_r.ts == '0) begin
          s_nxt.kr = 32'h0;
          s_nxt.st = PIDC_ST_STEP;
        end else begin
          s_nxt.div_start = 1'b1;
          s_nxt.st = PIDC_ST_KR_W;
        end
      end
      PIDC_ST_KR_W: begin
        if (div_done) begin
          s_nxt.kr = sat31(div_quo);
          s_nxt.st = PIDC_ST_STEP;
        end
      end
      PIDC_ST_STEP: begin
        if (s_r.first) begin
          s_nxt.mx = s_r.init;
          s_nxt.st = PIDC_ST_CALC;
        end else if (s_r.ctrl.step_bias && !s_r.ctrl.freeze && s_r.sp != s_r.sp_prev &&
                     s_r.sp != '0 && s_r.sp_prev != '0) begin
          if (s_r.ctrl.reverse) begin
            s_nxt.div_req = '{num: 48'(s_r.mx) * 48'(s_r.sp_prev), den: 16'(s_r.sp)};
          end else begin
            s_nxt.div_req = '{num: 48'(s_r.mx) * 48'(s_r.sp), den: 16'(s_r.sp_prev)};
          end
          s_nxt.div_start = 1'b1;
          s_nxt.st = PIDC_ST_STEP_W;
        end else begin
          s_nxt.st = PIDC_ST_CALC;
        end
      end
      PIDC_ST_STEP_W: begin
        if (div_done) begin
          s_nxt.mx = (div_quo > 48'(PIDC_ONE)) ? 17'(PIDC_ONE) : div_quo[16:0];
          s_nxt.st = PIDC_ST_CALC;
        end
      end
      PIDC_ST_CALC: begin
        s_nxt.mx = mxn[16:0];
        s_nxt.at_limit = (m != mcl);
        s_nxt.frozen = (m != mcl) && s_r.ctrl.freeze;
        s_nxt.cv = cv_code;
        s_nxt.delta = 13'($signed({1'b0, cv_code}) - $signed({1'b0, s_r.cv}));
        s_nxt.cv_valid = 1'b1;
        s_nxt.pv_prev = s_r.pv;
        s_nxt.sp_prev = s_r.sp;
        s_nxt.first = 1'b0;
        s_nxt.st = PIDC_ST_IDLE;
      end
    endcase

    // bumpless entry to automatic; placed last so it wins over a bus write
    s_nxt.auto_prev = s_r.ctrl.auto_mode;
    if (s_r.ctrl.auto_mode && !s_r.auto_prev) begin
      s_nxt.sp = s_r.pv_last;
      s_nxt.sp_prev = s_r.pv_last;
      s_nxt.pv_prev = s_r.pv_last;
      if (!s_r.ctrl.velocity) begin
        s_nxt.mx = {1'b0, s_r.cv, 4'h0};
        s_nxt.first = 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      s_r <= '0;
      s_r.gain <= PIDC_RST_GAIN;
      s_r.ti <= PIDC_RST_INTEG_TIME;
      s_r.td <= PIDC_RST_DERIV_TIME;
      s_r.ts <= PIDC_RST_SAMPLE_PERIOD;
      s_r.init <= PIDC_RST_INIT_OUT;
      s_r.mx <= PIDC_RST_INIT_OUT;
      s_r.lim_min <= PIDC_RST_MIN;
      s_r.lim_max <= PIDC_RST_MAX;
      s_r.first <= 1'b1;
      s_r.st <= PIDC_ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  pidc_div #(.NW(48), .DW(16)) u_div (
    .i_clk(I_CLK),
    .i_resetn(I_RESETN),
    .i_start(s_r.div_start),
    .i_req(s_r.div_req),
    .o_done(div_done),
    .o_quo(div_quo)
  );

  assign O_AWREADY = aw_rdy;
  assign O_WREADY = w_rdy;
  assign O_BVALID = s_r.bvalid;
  assign O_BRESP = s_r.bresp;
  assign O_ARREADY = ar_rdy;
  assign O_RVALID = s_r.rvalid;
  assign O_RDATA = s_r.rdata;
  assign O_RRESP = s_r.rresp;
  assign O_CV_VALID = s_r.cv_valid;
  assign O_CV = s_r.cv;
  assign O_CV_DELTA = s_r.delta;

endmodule : pidc_top

// file: core/pidc_pkg.sv
// pidc_pkg: shared constants and types of the pid loop calculator.
// assumes a 32-bit axi4-lite register bus and 12-bit unipolar converters.
package pidc_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] PIDC_OFF_CTRL = 8'h00;
  localparam logic [7:0] PIDC_OFF_SETPOINT = 8'h04;
  localparam logic [7:0] PIDC_OFF_GAIN = 8'h08;
  localparam logic [7:0] PIDC_OFF_INTEG_TIME = 8'h0c;
  localparam logic [7:0] PIDC_OFF_DERIV_TIME = 8'h10;
  localparam logic [7:0] PIDC_OFF_SAMPLE_PERIOD = 8'h14;
  localparam logic [7:0] PIDC_OFF_INIT_OUT = 8'h18;
  localparam logic [7:0] PIDC_OFF_OUT_LIMITS = 8'h1c;
  localparam logic [7:0] PIDC_OFF_MANUAL_OUT = 8'h20;
  localparam logic [7:0] PIDC_OFF_STATUS = 8'h24;
  localparam logic [7:0] PIDC_OFF_BIAS = 8'h28;
  localparam logic [7:0] PIDC_OFF_INTEG_COEF = 8'h2c;
  localparam logic [7:0] PIDC_OFF_DERIV_COEF = 8'h30;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int PIDC_CTRL_AUTO = 0;
  localparam int PIDC_CTRL_VELOCITY = 1;
  localparam int PIDC_CTRL_FREEZE = 2;
  localparam int PIDC_CTRL_STEP_BIAS = 3;
  localparam int PIDC_CTRL_REVERSE = 4;
  localparam int PIDC_CTRL_LOAD_INIT = 5;
  localparam int PIDC_LIM_MAX_LSB = 16;
  localparam int PIDC_STAT_BUSY = 16;
  localparam int PIDC_STAT_LIMIT = 17;
  localparam int PIDC_STAT_FROZEN = 18;

  // ****************************************************************
  // number formats and reset values
  // ****************************************************************
  localparam logic signed [31:0] PIDC_ONE = 32'sh0001_0000; // 1.0 in q16.16
  localparam int PIDC_FRAC = 16;
  localparam int PIDC_CONV_SHIFT = 4; // 12-bit code to q16 fraction
  localparam logic [15:0] PIDC_TI_OFF_LO = 16'h0000;
  localparam logic [15:0] PIDC_TI_OFF_HI = 16'h270f; // 9999
  localparam logic [11:0] PIDC_CODE_MAX = 12'hfff;
  localparam logic [31:0] PIDC_RST_GAIN = 32'h0001_0000;
  localparam logic [15:0] PIDC_RST_INTEG_TIME = 16'h0000;
  localparam logic [15:0] PIDC_RST_DERIV_TIME = 16'h0000;
  localparam logic [15:0] PIDC_RST_SAMPLE_PERIOD = 16'h0001;
  localparam logic [16:0] PIDC_RST_INIT_OUT = 17'h0_0000;
  localparam logic [11:0] PIDC_RST_MIN = 12'h000;
  localparam logic [11:0] PIDC_RST_MAX = 12'hfff;
  localparam logic [1:0] PIDC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PIDC_RESP_SLVERR = 2'h2;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    PIDC_ST_IDLE, PIDC_ST_KI, PIDC_ST_KI_W, PIDC_ST_KR, PIDC_ST_KR_W,
    PIDC_ST_STEP, PIDC_ST_STEP_W, PIDC_ST_CALC
  } pidc_state_e;

  // first member is the msb: listed from bit 4 down so each lands on its control bit
  typedef struct packed {
    logic reverse;
    logic step_bias;
    logic freeze;
    logic velocity;
    logic auto_mode;
  } pidc_ctrl_s;

  typedef struct packed {
    logic [47:0] num;
    logic [15:0] den;
  } pidc_div_req_s;

endpackage : pidc_pkg

// file: core/pidc_div.sv
// pidc_div: sequential unsigned restoring divider, one quotient bit per clock.
// assumes the caller holds off a new start until done; divide by zero gives all ones.
`timescale 1ns/1ps
module pidc_div import pidc_pkg::*; #(
  parameter int NW = 48,
  parameter int DW = 16
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_start,
  input wire pidc_div_req_s i_req,
  output logic o_done,
  output logic [NW-1:0] o_quo
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [7:0] cnt;
    logic [DW:0] rem;
    logic [NW-1:0] quo;
    logic [DW-1:0] den;
  } pidc_div_s;

  pidc_div_s s_r, s_nxt;
  logic [DW:0] trial;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    trial = {s_r.rem[DW-1:0], s_r.quo[NW-1]};
    if (i_start && !s_r.busy) begin
      s_nxt.busy = 1'b1;
      s_nxt.cnt = 8'(NW);
      s_nxt.rem = '0;
      s_nxt.quo = i_req.num;
      s_nxt.den = i_req.den;
    end else if (s_r.busy) begin
      // shift one numerator bit into the remainder, subtract when it fits
      if (trial >= {1'b0, s_r.den}) begin
        s_nxt.rem = trial - {1'b0, s_r.den};
        s_nxt.quo = {s_r.quo[NW-2:0], 1'b1};
      end else begin
        s_nxt.rem = trial;
        s_nxt.quo = {s_r.quo[NW-2:0], 1'b0};
      end
      s_nxt.cnt = s_r.cnt - 8'h01;
      if (s_r.cnt == 8'h01) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_done = s_r.done;
  assign o_quo = s_r.quo;

endmodule : pidc_div

// file: sim/pidc_top_chk.sv
// pidc_top_chk: port assertions of the pid loop calculator.
// assumes one clock domain and the pidc_top port list.
`timescale 1ns/1ps
module pidc_top_chk (
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic I_AWVALID,
  input wire logic O_AWREADY,
  input wire logic I_WVALID,
  input wire logic O_WREADY,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [1:0] O_BRESP,
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic O_RVALID,
  input wire logic I_PV_VALID,
  input wire logic O_CV_VALID,
  input wire logic [11:0] O_CV,
  input wire logic signed [12:0] O_CV_DELTA
);
  typedef struct packed {
    logic [7:0] since;
    logic [1:0] outs;
  } pidc_chk_s;
  pidc_chk_s st_r;
  pidc_chk_s st_nxt;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  // both counts saturate so a long idle gap never wraps back into range
  always_comb begin
    st_nxt = st_r;
    if (st_r.since != 8'hff) st_nxt.since = st_r.since + 8'h01;
    if (O_CV_VALID && st_r.outs != 2'h3) st_nxt.outs = st_r.outs + 2'h1;
    if (I_PV_VALID) st_nxt = '0;
  end
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) st_r <= '0;
    else st_r <= st_nxt;
  end
  // ********
  // assertions
  // ********
  AST_CV_PULSE: assert property (O_CV_VALID |=> !O_CV_VALID)
    else $error("output strobe too long");
  AST_ONE_CALC: assert property (st_r.outs <= 2'h1)
    else $error("two outputs for one sample");
  AST_CV_SOON: assert property (O_CV_VALID |-> st_r.since <= 8'ha0)
    else $error("output without recent sample");
  AST_DELTA: assert property (O_CV_VALID |-> O_CV_DELTA == $signed({1'b0, O_CV}) - $signed({1'b0, $past(O_CV)}))
    else $error("delta not new minus old");
  AST_CV_HOLD: assert property (!O_CV_VALID |-> $stable(O_CV) && $stable(O_CV_DELTA))
    else $error("output moved without strobe");
  AST_B_SOON: assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##2 O_BVALID)
    else $error("write response late");
  AST_B_BLOCK: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
    else $error("write taken during response");
  AST_B_DROP: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
    else $error("write response repeated");
  AST_R_SOON: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read data late");
  cover property (O_CV_VALID && O_CV == 12'hfff);
  cover property (O_BVALID && O_BRESP == 2'h2);
  cover property (O_CV_VALID && O_CV_DELTA < 0);
endmodule : pidc_top_chk

bind pidc_top pidc_top_chk pidc_top_chk_inst (.I_CLK, .I_RESETN, .I_AWVALID, .O_AWREADY, .I_WVALID, .O_WREADY,
  .O_BVALID, .I_BREADY, .O_BRESP, .I_ARVALID, .O_ARREADY, .O_RVALID, .I_PV_VALID, .O_CV_VALID, .O_CV, .O_CV_DELTA);

// file: sim/pidc_conv_model.sv
// pidc_conv_model: input converter giving samples, output converter taking codes.
// assumes one output strobe answers each sample.
`timescale 1ns/1ps
module pidc_conv_model (
  input wire logic i_clk,
  output logic o_pv_valid,
  output logic [11:0] o_pv,
  input wire logic i_cv_valid,
  input wire logic [11:0] i_cv,
  input wire logic signed [12:0] i_cv_delta
);
  logic ok_r;
  logic [11:0] cv_r;
  logic signed [12:0] delta_r;
  initial begin
    o_pv_valid = 1'b0;
    o_pv = 12'h000;
  end
  // spacing comes first so a slow calculation never sees a refused sample
  task automatic sample(input logic [11:0] p);
    int n;
    repeat (160) @(posedge i_clk);
    o_pv_valid <= 1'b1;
    o_pv <= p;
    @(posedge i_clk);
    o_pv_valid <= 1'b0;
    // the code is not held after the strobe
    o_pv <= ~p;
    ok_r = 1'b0;
    for (n = 0; n < 300 && !ok_r; n++) begin
      @(posedge i_clk);
      if (i_cv_valid === 1'b1) begin
        ok_r = 1'b1;
        cv_r = i_cv;
        delta_r = i_cv_delta;
      end
    end
  endtask : sample
endmodule : pidc_conv_model

// file: sim/testbench.sv
// testbench: self-checking bench of the pid loop calculator.
// assumes the converter model and the bound checker beside it.
`timescale 1ns/1ps
module testbench import pidc_pkg::*;;
  typedef struct packed {
    logic [11:0] sp;
    logic [11:0] pv;
    logic [31:0] lim;
    logic [11:0] cv;
  } pidc_row_s;
  logic clk;
  logic rstn = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, d_g, rdat;
  logic [1:0] r_g, br, rr;
  logic [11:0] last = 12'h000, pv, cv;
  logic awr, wrd, bv, arr, rv, pvv, cvv;
  logic signed [12:0] cvd;
  int error_cnt = 0, cmp_count = 0;
  logic [7:0] ra[6] = '{PIDC_OFF_CTRL, PIDC_OFF_GAIN, PIDC_OFF_SAMPLE_PERIOD, PIDC_OFF_OUT_LIMITS, PIDC_OFF_BIAS, 8'h40};
  logic [31:0] re[6] = '{32'h0, 32'h1_0000, 32'h1, 32'h0fff_0000, 32'h0, 32'h0};
  pidc_row_s rows[7] = '{
    '{12'h800, 12'h800, 32'h0fff_0000, 12'h800}, '{12'h800, 12'h700, 32'h0fff_0000, 12'h900},
    '{12'h900, 12'ha00, 32'h0fff_0000, 12'h700}, '{12'hfff, 12'h000, 32'h0c00_0100, 12'hc00},
    '{12'h000, 12'hfff, 32'h0c00_0100, 12'h100}, '{12'hfff, 12'h000, 32'h0fff_0000, 12'hfff},
    '{12'h000, 12'hfff, 32'h0fff_0000, 12'h000}};
  pidc_top pidc_top_inst (.I_CLK(clk), .I_RESETN(rstn), .I_AWVALID(awv), .O_AWREADY(awr), .I_AWADDR(awa),
    .I_AWPROT(3'h0), .I_WVALID(wv), .O_WREADY(wrd), .I_WDATA(wd), .I_WSTRB(4'hf), .O_BVALID(bv),
    .I_BREADY(bry), .O_BRESP(br), .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara), .I_ARPROT(3'h0),
    .O_RVALID(rv), .I_RREADY(rry), .O_RDATA(rdat), .O_RRESP(rr), .I_PV_VALID(pvv), .I_PV(pv),
    .O_CV_VALID(cvv), .O_CV(cv), .O_CV_DELTA(cvd));
  pidc_conv_model pidc_conv_model_inst (.i_clk(clk), .o_pv_valid(pvv), .o_pv(pv), .i_cv_valid(cvv),
    .i_cv(cv), .i_cv_delta(cvd));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic close_out();
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  task automatic timeout();
    $display("Error %0t: no answer", $time);
    error_cnt++;
    close_out();
  endtask : timeout
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // ********
  // bus cycles
  // ********
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= d;
    bry <= 1'b1;
    for (n = 0; n < 50 && bv !== 1'b1; n++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end
    r_g = br;
    bry <= 1'b0;
    if (n == 50) timeout();
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    int n;
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rry <= 1'b1;
    for (n = 0; n < 50 && rv !== 1'b1; n++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end
    r_g = rr;
    rry <= 1'b0;
    if (n == 50) timeout();
    chk(rdat, e);
  endtask : rc
  task automatic smp(input logic [11:0] p, input logic [11:0] e);
    logic signed [12:0] dx;
    dx = {1'b0, e} - {1'b0, last};
    last = e;
    pidc_conv_model_inst.sample(p);
    if (!pidc_conv_model_inst.ok_r) timeout();
    chk(32'(pidc_conv_model_inst.cv_r), 32'(e));
    chk(32'(pidc_conv_model_inst.delta_r), 32'(dx));
  endtask : smp
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    wr(PIDC_OFF_MANUAL_OUT, 32'h800);
    smp(12'h300, 12'h800);
    wr(PIDC_OFF_INIT_OUT, 32'h8000);
    wr(PIDC_OFF_CTRL, 32'h1);
    rc(PIDC_OFF_SETPOINT, 32'h300);
    rc(PIDC_OFF_BIAS, 32'h8000);
    foreach (rows[i]) begin
      wr(PIDC_OFF_SETPOINT, 32'(rows[i].sp));
      wr(PIDC_OFF_OUT_LIMITS, rows[i].lim);
      smp(rows[i].pv, rows[i].cv);
    end
    wr(PIDC_OFF_GAIN, 32'h2_0000);
    wr(PIDC_OFF_INTEG_TIME, 32'h1);
    wr(PIDC_OFF_SETPOINT, 32'h800);
    wr(PIDC_OFF_CTRL, 32'h21);
    rc(PIDC_OFF_BIAS, 32'h8000);
    smp(12'h7f0, 12'h840);
    rc(PIDC_OFF_BIAS, 32'h8200);
    rc(PIDC_OFF_INTEG_COEF, 32'h2_0000);
    wr(PIDC_OFF_INTEG_TIME, 32'h270f);
    smp(12'h7f0, 12'h840);
    rc(PIDC_OFF_BIAS, 32'h8200);
    wr(PIDC_OFF_INTEG_TIME, 32'h1);
    wr(PIDC_OFF_CTRL, 32'h5);
    smp(12'h000, 12'hfff);
    rc(PIDC_OFF_BIAS, 32'h8200);
    wr(PIDC_OFF_CTRL, 32'h1);
    smp(12'h000, 12'hfff);
    rc(PIDC_OFF_BIAS, 32'h0);
    wr(PIDC_OFF_GAIN, 32'h1_0000);
    wr(PIDC_OFF_INTEG_TIME, 32'h0);
    wr(PIDC_OFF_SETPOINT, 32'h800);
    wr(PIDC_OFF_CTRL, 32'h29);
    smp(12'h800, 12'h800);
    wr(PIDC_OFF_SETPOINT, 32'h400);
    smp(12'h400, 12'h400);
    wr(PIDC_OFF_CTRL, 32'hd);
    wr(PIDC_OFF_SETPOINT, 32'h200);
    smp(12'h200, 12'h400);
    wr(PIDC_OFF_GAIN, 32'h0);
    wr(PIDC_OFF_INTEG_TIME, 32'h2);
    wr(PIDC_OFF_DERIV_TIME, 32'h3);
    smp(12'h200, 12'h400);
    rc(PIDC_OFF_INTEG_COEF, 32'h8000);
    rc(PIDC_OFF_DERIV_COEF, 32'h3_0000);
    smp(12'h210, 12'h3c8);
    // reverse acting with step bias, then a manual to velocity-auto change
    wr(PIDC_OFF_CTRL, 32'h19);
    wr(PIDC_OFF_SETPOINT, 32'h400);
    smp(12'h210, 12'h104);
    wr(PIDC_OFF_CTRL, 32'h0);
    wr(PIDC_OFF_CTRL, 32'h3);
    rc(PIDC_OFF_SETPOINT, 32'h210);
    rc(PIDC_OFF_BIAS, 32'h1040);
    // second reset in mid-run, then the reset values
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    foreach (ra[i]) rc(ra[i], re[i]);
    chk(32'(r_g), 32'(PIDC_RESP_SLVERR));
    wr(8'h40, 32'h1);
    chk(32'(r_g), 32'(PIDC_RESP_SLVERR));
    wr(PIDC_OFF_BIAS, 32'h1234);
    chk(32'(r_g), 32'(PIDC_RESP_OKAY));
    rc(PIDC_OFF_BIAS, 32'h0);
    close_out();
  end
endmodule : testbench
